// ===== boot_loader_checker.sv
// port assertions for the boot loader mode controller
`timescale 1ns/1ps
`default_nettype none
module boot_loader_checker
  import boot_loader_pkg::*;
#(
  parameter int unsigned UART_LOAD = 32,
  parameter int unsigned CAN_LOAD = 128,
  parameter int unsigned CNT_W = 8
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic HW_RST_DONE,
  input wire logic SW_RST,
  input wire logic BOOT_STRAP_PIN,
  input wire logic EXTERNAL_ACCESS_PIN,
  input wire logic BUS_WIDTH8,
  input wire logic [1:0] BUS_TYPE_STRAP,
  input wire logic SEG8_SELECT,
  input wire logic FL_REQ,
  input wire logic [1:0] FL_KIND,
  input wire logic [23:0] FL_ADDR,
  input wire logic BOOT_LOADER_MODE,
  input wire logic WDT_DISABLE,
  input wire preset_t PRESET,
  input wire pin_ctl_t PINS,
  input wire logic RAM_WE,
  input wire logic [23:0] RAM_ADDR,
  input wire logic JUMP,
  input wire logic RESTART,
  input wire logic FL_VALID,
  input wire fl_resp_t FL_RESP
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire logic entry = HW_RST_DONE && !BOOT_STRAP_PIN;
  chk_entry_mode: assert property (entry |=> BOOT_LOADER_MODE && WDT_DISABLE)
    else $error("loader mode not entered");
  chk_system_config_reg_preset: assert property (entry |=> (PRESET.system_config_reg & 16'hfdfb) ==
    (SYSTEM_CONFIG_REG_BOOT & 16'hfdfb) && PRESET.system_config_reg[BYTE_HIGH_DISABLE_BIT_BIT] == $past(BUS_WIDTH8))
    else $error("system config preset wrong");
  chk_bus_off: assert property (entry && EXTERNAL_ACCESS_PIN |=> PRESET.buscon == BUSCON_OFF)
    else $error("bus config not cleared");
  chk_bus_on: assert property (entry && !EXTERNAL_ACCESS_PIN |=> PRESET.buscon[10:9] == 2'b11
    && PRESET.buscon[7:6] == $past(BUS_TYPE_STRAP)) else $error("bus config not enabled");
  chk_uart_preset: assert property ($rose(PINS.uart_tx_dir) |-> PRESET.serial_control_reg == SERIAL_CONTROL_REG_BOOT
    && PINS.uart_tx && !PINS.can_tx_dir) else $error("uart preset wrong");
  chk_can_preset: assert property ($rose(PINS.can_tx_dir) |-> PRESET.ext_periph_select_reg == EXT_PERIPH_SELECT_REG_CAN
    && PRESET.canctl == CANCTL_BOOT && PRESET.system_config_reg[EXT_PERIPH_ENABLE_BIT_BIT] && !PINS.uart_tx_dir)
    else $error("can preset wrong");
  chk_can_withheld: assert property (SEG8_SELECT |=> !PINS.can_pins_en)
    else $error("can pins given with eight segments");
  chk_ram_window: assert property (RAM_WE |-> RAM_ADDR >= LOAD_BASE
    && RAM_ADDR < LOAD_BASE + CAN_LOAD) else $error("load address out of window");
  chk_jump_stay: assert property (JUMP |-> RAM_WE && BOOT_LOADER_MODE ##1 BOOT_LOADER_MODE)
    else $error("jump left loader mode");
  chk_fetch_test: assert property (FL_REQ && BOOT_LOADER_MODE && FL_KIND == ACC_FETCH
    && FL_ADDR <= TEST_HI |=> FL_VALID && FL_RESP.target == TGT_TEST)
    else $error("fetch not from test flash");
  chk_soft_exit: assert property (BOOT_LOADER_MODE && SW_RST && !HW_RST_DONE
    |=> !BOOT_LOADER_MODE && RESTART) else $error("soft reset did not exit");
  cover property (JUMP);
  cover property (RESTART);
  cover property (FL_VALID && FL_RESP.target == TGT_DENY);
endmodule
bind boot_loader_mode_ctrl boot_loader_checker #(
  .UART_LOAD(UART_LOAD), .CAN_LOAD(CAN_LOAD), .CNT_W(CNT_W)
) chk_i (
  .CORE_CLK, .RST, .HW_RST_DONE, .SW_RST, .BOOT_STRAP_PIN, .EXTERNAL_ACCESS_PIN, .BUS_WIDTH8,
  .BUS_TYPE_STRAP, .SEG8_SELECT, .FL_REQ, .FL_KIND, .FL_ADDR, .BOOT_LOADER_MODE, .WDT_DISABLE,
  .PRESET, .PINS, .RAM_WE, .RAM_ADDR, .JUMP, .RESTART, .FL_VALID, .FL_RESP
);
`default_nettype wire

// ===== boot_loader_mode_ctrl.sv
// boot loader mode control: entry, presets, download, flash routing, exit
// Operation
// RULE1 - strap low at reset end starts loader
// RULE2 - host holds strap low during reset
// RULE3 - watchdog stays disabled in loader mode
// RULE4 - system config preset, peripheral bit conditional
// RULE5 - memory enable forced, byte disable from straps
// RULE6 - access pin high clears bus config
// RULE7 - access pin low enables bus, type from straps
// RULE8 - uart boot presets serial, baud, tx pin
// RULE9 - can boot clears control, timing, tx pin; the code loads timing from the link and drives the tx pin high
// RULE10 - can boot presets peripheral select register
// RULE11 - only the selected link transmit is output
// RULE12 - no execution from user flash in loader
// RULE13 - all fetches come from test flash window; the code denies user flash fetches and sends other fetches to external memory
// RULE14 - user flash read/write only, test hidden
// RULE15 - flash writes addressed in segment one
// RULE16 - reads placed by segment map bit
// RULE17 - store 32 or 128 bytes from load base
// RULE18 - jump to first byte, stay in loader
// RULE19 - eight segments withhold can pins
// RULE20 - exit on soft reset or strap high
// RULE21 - after exit start at vector zero
// RULE22 - degenerated soft reset resamples the strap
`timescale 1ns/1ps
`default_nettype none
module boot_loader_mode_ctrl
  import boot_loader_pkg::*;
#(
  parameter int unsigned UART_LOAD = UART_BYTES,
  parameter int unsigned CAN_LOAD = CAN_BYTES,
  parameter int unsigned CNT_W = 8
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic HW_RST_DONE,
  input wire logic SW_RST,
  input wire logic BOOT_STRAP_PIN,
  input wire logic EXTERNAL_ACCESS_PIN,
  input wire logic ALT_BOOT,
  input wire logic BUS_WIDTH8,
  input wire logic [1:0] BUS_TYPE_STRAP,
  input wire logic SEG8_SELECT,
  input wire logic LINK_UART_DET,
  input wire logic LINK_CAN_DET,
  input wire logic [15:0] LINK_TIMING,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic FL_REQ,
  input wire logic [1:0] FL_KIND,
  input wire logic [23:0] FL_ADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic BOOT_LOADER_MODE,
  output logic WDT_DISABLE,
  output preset_t PRESET,
  output pin_ctl_t PINS,
  output logic RAM_WE,
  output logic [23:0] RAM_ADDR,
  output logic [7:0] RAM_DATA,
  output logic JUMP,
  output logic [23:0] JUMP_ADDR,
  output logic RESTART,
  output tgt_t RESTART_TARGET,
  output logic FL_VALID,
  output fl_resp_t FL_RESP
);

  if (UART_LOAD < 1 || CAN_LOAD < 1 || CAN_LOAD >= (1 << CNT_W)
      || UART_LOAD >= (1 << CNT_W) || CNT_W > 28) begin : g_chk
    $error("byte counter width does not suit the load counts");
  end

  function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // outside loader mode the latched access pin picks user flash or external memory
  function automatic tgt_t norm_target(input logic ea_high);
    norm_target = ea_high ? TGT_USER : TGT_EXT;
  endfunction

  state_t state_q, state_d;
  link_t link_q;
  preset_t preset_q;
  pin_ctl_t pins_q;
  logic ea_high_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last_idx;
  logic ram_we_q, jump_q, restart_q, fl_valid_q;
  logic [23:0] ram_addr_q;
  logic [7:0] ram_data_q;
  tgt_t restart_tgt_q;
  fl_resp_t fl_resp_q;
  logic [31:0] prdata_q;

  // event decoding
  wire boot_mode = !state_q[0];
  wire apb_setup = PSEL && !PENABLE;
  wire apb_wr = PSEL && PENABLE && PWRITE;
  wire hit_ctrl = PADDR == OFF_CTRL;
  wire hit_status = PADDR == OFF_STATUS;
  wire hit_system_config_reg = PADDR == OFF_SYSTEM_CONFIG_REG;
  wire hit_buscon = PADDR == OFF_BUSCON;
  wire hit_any = hit_ctrl || hit_status || hit_system_config_reg || hit_buscon;
  wire reg_swrst = apb_wr && hit_ctrl && PWDATA[CTRL_SWRST_BIT];
  wire soft_exit = SW_RST || reg_swrst;
  wire hw_boot = HW_RST_DONE && !BOOT_STRAP_PIN; // RULE1 RULE2
  wire hw_norm = HW_RST_DONE && BOOT_STRAP_PIN; // RULE22
  // a hardware reset end outranks a soft reset in the same cycle
  wire go_normal = hw_norm || (soft_exit && !HW_RST_DONE && boot_mode); // RULE20
  wire can_ok = !SEG8_SELECT; // RULE19
  wire uart_pick = state_q == ST_WAIT_LINK && LINK_UART_DET;
  // uart takes priority when both detectors fire together
  wire can_pick = state_q == ST_WAIT_LINK && LINK_CAN_DET && !LINK_UART_DET && can_ok;
  wire rx_take = state_q == ST_LOAD && RX_VALID;
  wire rx_last = rx_take && cnt_q == last_idx;

  assign last_idx = (link_q == LINK_CAN) ? CNT_W'(CAN_LOAD - 1) : CNT_W'(UART_LOAD - 1);

  // startup presets shared by both link kinds
  logic [15:0] system_config_reg_entry, buscon_entry;
  always_comb begin
    system_config_reg_entry = SYSTEM_CONFIG_REG_BOOT; // RULE4
    system_config_reg_entry[EXT_PERIPH_ENABLE_BIT_BIT] = ALT_BOOT; // RULE4
    system_config_reg_entry[INTERNAL_MEM_ENABLE_BIT_BIT] = 1'b1; // RULE5
    system_config_reg_entry[BYTE_HIGH_DISABLE_BIT_BIT] = BUS_WIDTH8; // RULE5
    buscon_entry = BUSCON_OFF; // RULE6
    if (!EXTERNAL_ACCESS_PIN) begin
      buscon_entry[BUSACT_BIT] = 1'b1; // RULE7
      buscon_entry[LATCH_BIT] = 1'b1; // RULE7
      buscon_entry[BUS_TYPE_FIELD_LSB +: 2] = BUS_TYPE_STRAP; // RULE7
    end
  end

  always_comb begin
    state_d = state_q;
    if (hw_boot) begin
      state_d = ST_WAIT_LINK;
    end else if (go_normal) begin
      state_d = ST_NORMAL;
    end else begin
      unique case (state_q)
        ST_NORMAL: state_d = ST_NORMAL;
        ST_WAIT_LINK: begin
          if (uart_pick || can_pick) begin
            state_d = ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (rx_last) begin
            state_d = ST_RUN; // RULE18
          end
        end
        ST_RUN: state_d = ST_RUN;
        default: state_d = ST_NORMAL;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_q <= ST_NORMAL;
      link_q <= LINK_NONE;
      ea_high_q <= 1'b1;
    end else begin
      state_q <= state_d;
      // the access pin only counts as a hardware reset ends
      if (HW_RST_DONE) begin
        ea_high_q <= EXTERNAL_ACCESS_PIN;
      end
      if (hw_boot) begin
        link_q <= LINK_NONE;
      end else if (uart_pick) begin
        link_q <= LINK_UART;
      end else if (can_pick) begin
        link_q <= LINK_CAN;
      end
    end
  end

  // configuration presets; software may rewrite the system config later
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      preset_q <= '0;
    end else if (hw_boot) begin
      preset_q.system_config_reg <= system_config_reg_entry;
      preset_q.buscon <= buscon_entry;
      preset_q.cp <= CP_BOOT;
      preset_q.sp <= SP_BOOT;
      preset_q.stack_underflow_limit <= STACK_UNDERFLOW_LIMIT_BOOT;
      preset_q.stack_overflow_limit <= STACK_OVERFLOW_LIMIT_BOOT;
      preset_q.serial_control_reg <= ZERO16;
      preset_q.serial_baud_reg <= ZERO16;
      preset_q.canctl <= ZERO16;
      preset_q.canbtr <= ZERO16;
      preset_q.ext_periph_select_reg <= ZERO16;
    end else if (go_normal) begin
      // each field written once; this branch loads the normal reset values on exit
      preset_q.system_config_reg <= SYSTEM_CONFIG_REG_NORMAL;
      preset_q.buscon <= ZERO16;
      preset_q.serial_control_reg <= ZERO16;
      preset_q.serial_baud_reg <= ZERO16;
      preset_q.canctl <= ZERO16;
      preset_q.canbtr <= ZERO16;
      preset_q.ext_periph_select_reg <= ZERO16;
      preset_q.cp <= ZERO16;
      preset_q.sp <= ZERO16;
      preset_q.stack_underflow_limit <= ZERO16;
      preset_q.stack_overflow_limit <= ZERO16;
    end else if (uart_pick) begin
      preset_q.serial_control_reg <= SERIAL_CONTROL_REG_BOOT; // RULE8
      preset_q.serial_baud_reg <= LINK_TIMING; // RULE8
    end else if (can_pick) begin
      preset_q.canctl <= CANCTL_BOOT; // RULE9
      preset_q.canbtr <= LINK_TIMING; // RULE9
      preset_q.ext_periph_select_reg <= EXT_PERIPH_SELECT_REG_CAN; // RULE10
      preset_q.system_config_reg[EXT_PERIPH_ENABLE_BIT_BIT] <= 1'b1; // RULE4
    end else if (apb_wr && hit_system_config_reg) begin
      preset_q.system_config_reg <= PWDATA[15:0];
    end
  end

  // transmit pins: only the chosen link drives its line
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pins_q <= '0;
    end else begin
      pins_q.can_pins_en <= can_ok; // RULE19
      if (hw_boot || go_normal) begin
        pins_q.uart_tx <= 1'b0;
        pins_q.uart_tx_dir <= 1'b0;
        pins_q.can_tx <= 1'b0;
        pins_q.can_tx_dir <= 1'b0;
      end else if (uart_pick) begin
        pins_q.uart_tx <= 1'b1; // RULE8 RULE11
        pins_q.uart_tx_dir <= 1'b1; // RULE8 RULE11
      end else if (can_pick) begin
        pins_q.can_tx <= 1'b1; // RULE9 RULE11
        pins_q.can_tx_dir <= 1'b1; // RULE9 RULE11
      end
    end
  end

  // download into dual-port ram, then jump to its first byte
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cnt_q <= '0;
      ram_we_q <= 1'b0;
      ram_addr_q <= LOAD_BASE;
      ram_data_q <= '0;
      jump_q <= 1'b0;
    end else begin
      ram_we_q <= rx_take && !go_normal && !hw_boot;
      jump_q <= rx_last && !go_normal && !hw_boot; // RULE18
      // the count restarts at entry and at link choice, so a repeated boot starts clean
      if (hw_boot || uart_pick || can_pick) begin
        cnt_q <= '0;
      end else if (rx_take) begin
        cnt_q <= cnt_q + 1'b1; // RULE17
        ram_addr_q <= LOAD_BASE + 24'(cnt_q); // RULE17
        ram_data_q <= RX_DATA;
      end
    end
  end

  // leaving loader mode restarts at vector zero, target chosen by access pin
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      restart_q <= 1'b0;
      restart_tgt_q <= TGT_USER;
    end else begin
      restart_q <= go_normal && boot_mode; // RULE21
      if (go_normal) begin
        // a hardware exit reads the pin live; a soft exit keeps the latched level
        restart_tgt_q <= norm_target(hw_norm ? EXTERNAL_ACCESS_PIN : ea_high_q); // RULE21
      end
    end
  end

  // flash routing
  wire segmap = preset_q.system_config_reg[SEGMAP_BIT];
  wire a_test = in_rng(FL_ADDR, TEST_LO, TEST_HI);
  wire a_seg0 = in_rng(FL_ADDR, TEST_LO, SEG0_HI);
  wire a_user = in_rng(FL_ADDR, USER_LO, USER_HI);
  wire [23:0] user_off = FL_ADDR - USER_LO;
  // test flash only ever serves fetches; reads and writes never reach it
  fl_resp_t route;
  always_comb begin
    route.target = norm_target(ea_high_q); // RULE21
    route.offset = FL_ADDR;
    if (boot_mode) begin
      route.target = TGT_EXT;
      unique case (acc_t'(FL_KIND))
        ACC_FETCH: begin
          if (a_test) begin
            route.target = TGT_TEST; // RULE13
          end else if (a_user) begin
            // user flash fetches are refused, never executed
            route.target = TGT_DENY; // RULE12
          end
        end
        ACC_READ: begin
          if (a_user) begin
            route.target = TGT_USER; // RULE14
            route.offset = user_off;
          end else if (a_seg0 && !segmap) begin
            route.target = TGT_USER; // RULE16
          end
        end
        ACC_WRITE: begin
          if (a_user) begin
            route.target = TGT_USER; // RULE14 RULE15
            route.offset = user_off;
          end else if (a_seg0) begin
            route.target = TGT_DENY; // RULE14 RULE15
          end
        end
        default: route.target = TGT_DENY;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      fl_valid_q <= 1'b0;
      fl_resp_q <= '0;
    end else begin
      fl_valid_q <= FL_REQ;
      if (FL_REQ) begin
        fl_resp_q <= route;
      end
    end
  end

  // apb: read data captured in setup, answered with no wait state
  // the count is zero-extended, so the layout holds for any legal counter width
  wire [31:0] status_word = 32'({cnt_q, link_q, boot_mode, 1'b0});
  // read-only registers drop writes; unmapped offsets read zero with an error
  wire [31:0] rd_mux = hit_status ? status_word
                     : hit_system_config_reg ? {16'h0000, preset_q.system_config_reg}
                     : hit_buscon ? {16'h0000, preset_q.buscon}
                     : 32'h00000000;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      prdata_q <= '0;
    end else if (apb_setup) begin
      prdata_q <= PWRITE ? 32'h00000000 : rd_mux;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit_any;
  assign BOOT_LOADER_MODE = boot_mode;
  assign WDT_DISABLE = boot_mode; // RULE3 RULE18
  assign PRESET = preset_q;
  assign PINS = pins_q;
  assign RAM_WE = ram_we_q;
  assign RAM_ADDR = ram_addr_q;
  assign RAM_DATA = ram_data_q;
  assign JUMP = jump_q;
  assign JUMP_ADDR = LOAD_BASE; // RULE18
  assign RESTART = restart_q;
  assign RESTART_TARGET = restart_tgt_q;
  assign FL_VALID = fl_valid_q;
  assign FL_RESP = fl_resp_q;

endmodule
`default_nettype wire

// ===== boot_loader_pkg.sv
// constants and carrier types for the boot loader mode controller
package boot_loader_pkg;
  localparam int unsigned INTERNAL_MEM_ENABLE_BIT_BIT = 10;
  localparam int unsigned BYTE_HIGH_DISABLE_BIT_BIT = 9;
  localparam int unsigned EXT_PERIPH_ENABLE_BIT_BIT = 2;
  localparam int unsigned SEGMAP_BIT = 12;
  localparam int unsigned BUSACT_BIT = 10;
  localparam int unsigned LATCH_BIT = 9;
  localparam int unsigned BUS_TYPE_FIELD_LSB = 6;
  localparam logic [15:0] SYSTEM_CONFIG_REG_BOOT = 16'h0404;
  localparam logic [15:0] SYSTEM_CONFIG_REG_NORMAL = 16'h0000;
  localparam logic [15:0] BUSCON_OFF = 16'h0000;
  localparam logic [15:0] SERIAL_CONTROL_REG_BOOT = 16'h8011;
  localparam logic [15:0] CANCTL_BOOT = 16'h0000;
  localparam logic [15:0] EXT_PERIPH_SELECT_REG_CAN = 16'h042d;
  localparam logic [15:0] CP_BOOT = 16'hfa00;
  localparam logic [15:0] STACK_UNDERFLOW_LIMIT_BOOT = 16'hfc00;
  localparam logic [15:0] SP_BOOT = 16'hfa40;
  localparam logic [15:0] STACK_OVERFLOW_LIMIT_BOOT = 16'hfa00;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [23:0] LOAD_BASE = 24'h00fa40;
  localparam logic [23:0] RESET_VEC = 24'h000000;
  localparam logic [23:0] TEST_LO = 24'h000000;
  localparam logic [23:0] TEST_HI = 24'h001fff;
  localparam logic [23:0] SEG0_HI = 24'h007fff;
  localparam logic [23:0] USER_LO = 24'h010000;
  localparam logic [23:0] USER_HI = 24'h08ffff;
  localparam int unsigned UART_BYTES = 32;
  localparam int unsigned CAN_BYTES = 128;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SYSTEM_CONFIG_REG = 8'h08;
  localparam logic [7:0] OFF_BUSCON = 8'h0c;
  localparam int unsigned CTRL_SWRST_BIT = 0;

  typedef enum logic [3:0] {
    ST_NORMAL = 4'b0001,
    ST_WAIT_LINK = 4'b0010,
    ST_LOAD = 4'b0100,
    ST_RUN = 4'b1000
  } state_t;

  typedef enum logic [1:0] {
    LINK_NONE = 2'h0,
    LINK_UART = 2'h1,
    LINK_CAN = 2'h2
  } link_t;

  typedef enum logic [1:0] {
    ACC_FETCH = 2'h0,
    ACC_READ = 2'h1,
    ACC_WRITE = 2'h2
  } acc_t;

  typedef enum logic [1:0] {
    TGT_EXT = 2'h0,
    TGT_USER = 2'h1,
    TGT_TEST = 2'h2,
    TGT_DENY = 2'h3
  } tgt_t;

  typedef struct packed {
    logic [15:0] system_config_reg;
    logic [15:0] buscon;
    logic [15:0] serial_control_reg;
    logic [15:0] serial_baud_reg;
    logic [15:0] canctl;
    logic [15:0] canbtr;
    logic [15:0] ext_periph_select_reg;
    logic [15:0] cp;
    logic [15:0] sp;
    logic [15:0] stack_underflow_limit;
    logic [15:0] stack_overflow_limit;
  } preset_t;

  typedef struct packed {
    logic uart_tx;
    logic uart_tx_dir;
    logic can_tx;
    logic can_tx_dir;
    logic can_pins_en;
  } pin_ctl_t;

  typedef struct packed {
    tgt_t target;
    logic [23:0] offset;
  } fl_resp_t;
endpackage

// ===== host_link_model.sv
// host model: link detection pulse, then the download bytes
`timescale 1ns/1ps
`default_nettype none
module host_link_model #(
  parameter int UART_N = 32,
  parameter int CAN_N = 128
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic can,
  input wire logic [3:0] gap,
  output logic det_uart,
  output logic det_can,
  output logic [15:0] timing,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic busy
);
  logic [7:0] cnt_q;
  logic [3:0] wait_q;
  logic can_q;
  assign timing = can_q ? 16'h0321 : 16'h0123;
  always_ff @(posedge clk) begin
    det_uart <= 1'b0;
    det_can <= 1'b0;
    rx_valid <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
      can_q <= 1'b0;
      rx_data <= 8'h00;
    end else if (go && !busy) begin
      busy <= 1'b1;
      can_q <= can;
      cnt_q <= 8'h00;
      wait_q <= gap;
      det_uart <= !can;
      det_can <= can;
    end else if (busy && wait_q == 4'h0 && cnt_q == 8'(can_q ? CAN_N : UART_N)) begin
      busy <= 1'b0;
    end else if (busy && wait_q == 4'h0) begin
      rx_valid <= 1'b1;
      rx_data <= cnt_q ^ 8'h5a;
      cnt_q <= cnt_q + 8'h01;
      wait_q <= gap;
    end else begin
      // idle data line inverts every cycle instead of holding the last byte
      rx_data <= ~rx_data;
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the boot loader mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import boot_loader_pkg::*;
  logic clk = 0, rst = 1, hw = 0, sw = 0, strap = 1, ea = 1, alt = 0, w8 = 0, seg8 = 0;
  logic go = 0, can = 0, flreq = 0, psel = 0, pen = 0, pwr = 0, err;
  logic [1:0] btype = 2'h0, flkind = 2'h0;
  logic [3:0] gap = 4'h0;
  logic [7:0] paddr = 8'h00, rxd, ram_data;
  logic [15:0] timing, e;
  logic [23:0] fladdr = 24'h0, ram_addr, jaddr;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic det_u, det_c, rxv, busy, pready, pslverr, mode, wdt, ram_we, jump, restart, flv;
  preset_t pre;
  pin_ctl_t pins;
  tgt_t rtgt, rs_t;
  fl_resp_t flr;
  int bad_count = 0, n_compared = 0, wr_n = 0, jumps = 0;

  initial forever #4 clk = ~clk;

  host_link_model host_i (.clk(clk), .rst(rst), .go(go), .can(can), .gap(gap), .det_uart(det_u),
    .det_can(det_c), .timing(timing), .rx_valid(rxv), .rx_data(rxd), .busy(busy));

  boot_loader_mode_ctrl uut (.CORE_CLK(clk), .RST(rst), .HW_RST_DONE(hw), .SW_RST(sw),
    .BOOT_STRAP_PIN(strap), .EXTERNAL_ACCESS_PIN(ea), .ALT_BOOT(alt), .BUS_WIDTH8(w8),
    .BUS_TYPE_STRAP(btype), .SEG8_SELECT(seg8), .LINK_UART_DET(det_u), .LINK_CAN_DET(det_c),
    .LINK_TIMING(timing), .RX_VALID(rxv), .RX_DATA(rxd), .FL_REQ(flreq), .FL_KIND(flkind),
    .FL_ADDR(fladdr), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BOOT_LOADER_MODE(mode),
    .WDT_DISABLE(wdt), .PRESET(pre), .PINS(pins), .RAM_WE(ram_we), .RAM_ADDR(ram_addr),
    .RAM_DATA(ram_data), .JUMP(jump), .JUMP_ADDR(jaddr), .RESTART(restart), .RESTART_TARGET(rtgt),
    .FL_VALID(flv), .FL_RESP(flr));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
  endtask

  // which: 0 hardware reset end, 1 software reset
  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) hw <= 1;
    else sw <= 1;
    @(posedge clk);
    hw <= 0;
    sw <= 0;
    @(posedge clk);
    #1;
  endtask

  // deny answers carry no meaningful offset, so only the valid flag and target are compared
  task automatic fl(input acc_t k, input logic [23:0] a, input tgt_t t, input logic [23:0] o);
    @(posedge clk);
    flreq <= 1;
    flkind <= k;
    fladdr <= a;
    @(posedge clk);
    flreq <= 0;
    #1;
    chk({flv, flr.target, (t == TGT_DENY) ? 24'h0 : flr.offset}, {1'b1, t, o});
  endtask

  task automatic host(input logic c, input logic [3:0] g);
    @(posedge clk);
    can <= c;
    gap <= g;
    go <= 1;
    wr_n = 0;
    jumps = 0;
    @(posedge clk);
    go <= 0;
    do @(posedge clk); while (busy);
    repeat (3) @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    if (ram_we === 1'b1) begin
      chk({ram_addr, ram_data}, {LOAD_BASE + 24'(wr_n), 8'(wr_n) ^ 8'h5a});
      wr_n++;
    end
    if (jump === 1'b1) jumps++;
    if (restart === 1'b1) rs_t = rtgt;
  end

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done;
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    pulse(0);
    chk(mode, 0);
    fl(ACC_FETCH, 24'h000100, TGT_USER, 24'h000100);
    $display("test normal start done");
    strap <= 0;
    w8 <= 1;
    pulse(0);
    e = SYSTEM_CONFIG_REG_BOOT;
    e[EXT_PERIPH_ENABLE_BIT_BIT] = 0;
    e[BYTE_HIGH_DISABLE_BIT_BIT] = 1;
    chk({mode, wdt}, 2'b11);
    chk({pre.system_config_reg, pre.buscon}, {e, BUSCON_OFF});
    chk({pre.cp, pre.sp}, {CP_BOOT, SP_BOOT});
    chk({pre.stack_underflow_limit, pre.stack_overflow_limit}, {STACK_UNDERFLOW_LIMIT_BOOT, STACK_OVERFLOW_LIMIT_BOOT});
    host(0, 4'h2);
    chk({wr_n[15:0], jumps[15:0]}, {16'd32, 16'd1});
    chk(jaddr, LOAD_BASE);
    chk({pre.serial_control_reg, pre.serial_baud_reg}, {SERIAL_CONTROL_REG_BOOT, 16'h0123});
    chk(pins, 5'b11001);
    apb(0, OFF_STATUS, 32'h0);
    chk(rd, {20'h0, 8'd32, LINK_UART, 2'b10});
    fl(ACC_FETCH, 24'h001ffe, TGT_TEST, 24'h001ffe);
    fl(ACC_FETCH, 24'h010000, TGT_DENY, 24'h0);
    fl(ACC_READ, 24'h010004, TGT_USER, 24'h000004);
    fl(ACC_READ, 24'h000006, TGT_USER, 24'h000006);
    fl(ACC_WRITE, 24'h010008, TGT_USER, 24'h000008);
    fl(ACC_WRITE, 24'h000008, TGT_DENY, 24'h0);
    apb(1, OFF_SYSTEM_CONFIG_REG, {16'h0, e | 16'h1000});
    fl(ACC_READ, 24'h000006, TGT_EXT, 24'h000006);
    apb(0, OFF_SYSTEM_CONFIG_REG, 32'h0);
    chk(rd, {16'h0, e | 16'h1000});
    apb(0, 8'h10, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    pulse(1);
    chk({mode, 2'(rs_t)}, {1'b0, TGT_USER});
    $display("test uart boot done");
    ea <= 0;
    w8 <= 0;
    btype <= 2'b10;
    pulse(0);
    chk(pre.buscon, 16'h0680);
    apb(0, OFF_BUSCON, 32'h0);
    chk(rd, 32'h00000680);
    host(1, 4'h0);
    chk({wr_n[15:0], jumps[15:0]}, {16'd128, 16'd1});
    chk({pre.canctl, pre.canbtr}, {CANCTL_BOOT, 16'h0321});
    chk({pre.ext_periph_select_reg, pre.system_config_reg}, {EXT_PERIPH_SELECT_REG_CAN, SYSTEM_CONFIG_REG_BOOT});
    chk(pins, 5'b00111);
    pulse(0);
    chk(mode, 1);
    strap <= 1;
    pulse(0);
    chk({mode, 2'(rs_t)}, {1'b0, TGT_EXT});
    fl(ACC_FETCH, 24'h000000, TGT_EXT, 24'h000000);
    $display("test can boot done");
    seg8 <= 1;
    alt <= 1;
    strap <= 0;
    pulse(0);
    chk(pre.system_config_reg[EXT_PERIPH_ENABLE_BIT_BIT], 1);
    host(1, 4'h1);
    chk({wr_n[7:0], pins}, 13'h0);
    apb(1, OFF_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk(mode, 0);
    $display("test withheld can done");
    test_done;
  end
endmodule
`default_nettype wire
